// ### rtl/scsel_params.svh
`ifndef SCSEL_PARAMS_SVH
`define SCSEL_PARAMS_SVH
// protocol delays in ns
`define SCSEL_DESKEW_NS      45
`define SCSEL_SETTLE_NS      400
`define SCSEL_ABORT_NS       200000
`define SCSEL_TIMEOUT_NS     250000000
`define SCSEL_CLK_NS         20
// cycle counts, least times rounded up
`define SCSEL_DESKEW2_CYC    ((2*`SCSEL_DESKEW_NS + `SCSEL_CLK_NS - 1) / `SCSEL_CLK_NS)
`define SCSEL_SETTLE_CYC     ((`SCSEL_SETTLE_NS + `SCSEL_CLK_NS - 1) / `SCSEL_CLK_NS)
// longest time rounded down
`define SCSEL_ABORT_CYC      (`SCSEL_ABORT_NS / `SCSEL_CLK_NS)
`define SCSEL_TIMEOUT_CYC    (`SCSEL_TIMEOUT_NS / `SCSEL_CLK_NS)
`define SCSEL_ABORT2_CYC     (`SCSEL_ABORT_CYC + `SCSEL_DESKEW2_CYC)
`endif

// ### rtl/scsel_pkg.sv
package scsel_pkg;
  // phase code on {msg, cd, io}
  typedef enum logic [2:0] {
    PH_DATA_OUT = 3'h0,
    PH_DATA_IN  = 3'h1,
    PH_COMMAND  = 3'h2,
    PH_STATUS   = 3'h3,
    PH_MSG_OUT  = 3'h6,
    PH_MSG_IN   = 3'h7
  } scsel_phase_type;
endpackage

// ### rtl/scsel_bus_if.sv
`timescale 1ns/100ps
// shared bus: each party drives an active-high assert per line it owns, plus a data bus enable (low = driving)
interface scsel_bus_if;
  logic       tgt_bsy_o, ini_bsy_o, tgt_sel_o, ini_sel_o;
  logic       tgt_io_o, tgt_cd_o, tgt_msg_o, tgt_req_o;
  logic       ini_atn_o, ini_ack_o, tgt_rst_o, ini_rst_o;
  logic [8:0] tgt_db_o, ini_db_o;
  logic       tgt_db_oe_n, ini_db_oe_n;
  // line levels, wired-or for bsy, sel, rst and db, single-driver for the rest, true = asserted
  logic       bsy, sel, io, cd, msg, req, ack, atn, rst;
  logic [8:0] db;
  assign bsy = tgt_bsy_o | ini_bsy_o;
  assign sel = tgt_sel_o | ini_sel_o;
  assign io  = tgt_io_o;
  assign cd  = tgt_cd_o;
  assign msg = tgt_msg_o;
  assign req = tgt_req_o;
  assign ack = ini_ack_o;
  assign atn = ini_atn_o;
  assign rst = tgt_rst_o | ini_rst_o;
  assign db  = (tgt_db_oe_n ? 9'h000 : tgt_db_o) | (ini_db_oe_n ? 9'h000 : ini_db_o);
  modport tgt (output tgt_bsy_o, tgt_sel_o, tgt_io_o, tgt_cd_o, tgt_msg_o, tgt_req_o, tgt_rst_o,
               output tgt_db_o, tgt_db_oe_n, input bsy, sel, io, ack, atn, rst, db);
  modport ini (output ini_bsy_o, ini_sel_o, ini_atn_o, ini_ack_o, ini_rst_o, ini_db_o, ini_db_oe_n,
               input bsy, sel, io, cd, msg, req, rst, db);
endinterface

// ### rtl/scsel_target.sv
`timescale 1ns/100ps
`include "scsel_params.svh"
module scsel_target
  import scsel_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SCSEL_TIMEOUT_CYC,
  parameter int ABORT_CYC   = `SCSEL_ABORT_CYC
) (
  input  wire logic            mclk_i,        // system clock
  input  wire logic            reset_i,       // sync reset, high
  input  wire logic [7:0]      own_id_i,      // own id bit
  input  wire logic            resel_i,       // pulse: start reselection (bus already won)
  input  wire logic [7:0]      ini_id_i,      // initiator id bit for reselection
  input  wire logic            use_rst_i,     // timeout asserts rst instead of abort
  input  wire logic            xfer_i,        // pulse: move one byte
  input  wire scsel_phase_type phase_i,       // phase for next byte
  input  wire logic [7:0]      wdata_i,       // byte to send
  input  wire logic            release_i,     // pulse: leave the bus
  output logic                 connected_o,   // connection held
  output logic [7:0]           peer_id_o,     // other party id
  output logic                 busy_o,        // transfer in progress
  output logic                 done_o,        // byte moved pulse
  output logic [7:0]           rdata_o,       // received byte
  output logic                 timeout_o,     // reselection timed out pulse
  scsel_bus_if.tgt             bus            // scsi bus
);
  typedef enum logic [8:0] {
    T_IDLE = 9'h001, T_SELCHK = 9'h002, T_SELBSY = 9'h004, T_RSDSK = 9'h008, T_RSWAIT = 9'h010,
    T_RSABT = 9'h020, T_RSREL = 9'h040, T_CONN = 9'h080, T_XFER = 9'h100
  } scsel_tstate_type;

  // odd parity for bus byte
  function automatic logic par_ok(input logic [8:0] v);
    return ^v;
  endfunction
  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  // three-stage synchronisers, change taken when stages 2 and 3 agree
  logic [14:0] s1_q, s2_q, s3_q, in_q;
  logic [14:0] raw;
  assign raw = {bus.rst, bus.atn, bus.ack, bus.io, bus.sel, bus.bsy, bus.db};
  always_ff @(posedge mclk_i) begin
    s1_q <= raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    for (int i = 0; i < 15; i++) if (s2_q[i] == s3_q[i]) in_q[i] <= s3_q[i];
  end
  logic [8:0] db_s;
  logic bsy_s, sel_s, io_s, ack_s;
  assign db_s  = in_q[8:0];
  assign bsy_s = in_q[9];
  assign sel_s = in_q[10];
  assign io_s  = in_q[11];
  assign ack_s = in_q[12];

  // selection condition, screened for parity and id count
  logic sel_cond;
  assign sel_cond = sel_s & |(db_s[7:0] & own_id_i) & ~bsy_s & ~io_s
                    & par_ok(db_s) & (ones(db_s[7:0]) <= 4'h2);

  scsel_tstate_type st_q;
  logic [31:0] cnt_q;
  logic [31:0] abt_q;
  logic [7:0]  db_q;
  logic        bsy_q, sel_q, io_q, rst_q, dboe_n_q, req_q;
  logic [2:0]  ph_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= T_IDLE; cnt_q <= 32'h0; abt_q <= 32'h0; db_q <= 8'h00; bsy_q <= 1'b0; sel_q <= 1'b0;
      io_q <= 1'b0; rst_q <= 1'b0; dboe_n_q <= 1'b1; req_q <= 1'b0; ph_q <= 3'h0;
      peer_id_o <= 8'h00; rdata_o <= 8'h00; done_o <= 1'b0; timeout_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      case (st_q)
        T_IDLE: begin
          if (resel_i) begin
            io_q <= 1'b1; sel_q <= 1'b1; bsy_q <= 1'b1;
            db_q <= own_id_i | ini_id_i; dboe_n_q <= 1'b0;
            cnt_q <= 32'h0; st_q <= T_RSDSK;
          end else if (sel_cond) begin
            cnt_q <= cnt_q + 32'h1;
            if (cnt_q + 32'h1 >= 32'(`SCSEL_SETTLE_CYC)) begin
              peer_id_o <= db_s[7:0] & ~own_id_i;
              bsy_q <= 1'b1;
              abt_q <= 32'h0; st_q <= T_SELCHK;
            end
          end else cnt_q <= 32'h0;
        end
        T_SELCHK: begin
          // selection must still hold inside abort window of our bsy
          abt_q <= abt_q + 32'h1;
          if (sel_cond | (sel_s & ~io_s & bsy_s)) begin
            st_q <= T_SELBSY;
          end else if (abt_q >= 32'(ABORT_CYC - 1)) begin
            bsy_q <= 1'b0; cnt_q <= 32'h0; st_q <= T_IDLE;
          end
        end
        T_SELBSY: if (!sel_s) st_q <= T_CONN;
        T_RSDSK: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q + 32'h1 >= 32'(`SCSEL_DESKEW2_CYC)) begin
            bsy_q <= 1'b0; cnt_q <= 32'h0; st_q <= T_RSWAIT;
          end
        end
        T_RSWAIT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= 32'(`SCSEL_SETTLE_CYC) && bsy_s) begin
            bsy_q <= 1'b1; cnt_q <= 32'h0; st_q <= T_RSREL;
          end else if (cnt_q >= 32'(TIMEOUT_CYC)) begin
            cnt_q <= 32'h0;
            if (use_rst_i) begin
              rst_q <= 1'b1; st_q <= T_RSABT;
            end else begin
              dboe_n_q <= 1'b1; st_q <= T_RSABT;
            end
          end
        end
        T_RSABT: begin
          cnt_q <= cnt_q + 32'h1;
          if (bsy_s && !rst_q) begin
            bsy_q <= 1'b1; cnt_q <= 32'h0; st_q <= T_RSREL;
          end else if (cnt_q >= 32'(ABORT_CYC + `SCSEL_DESKEW2_CYC)) begin
            sel_q <= 1'b0; io_q <= 1'b0; rst_q <= 1'b0; dboe_n_q <= 1'b1;
            timeout_o <= 1'b1; st_q <= T_IDLE; cnt_q <= 32'h0;
          end
        end
        T_RSREL: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q + 32'h1 >= 32'(`SCSEL_DESKEW2_CYC)) begin
            sel_q <= 1'b0; dboe_n_q <= 1'b1; peer_id_o <= ini_id_i; st_q <= T_CONN;
            ph_q <= 3'h1; // io still asserted, so the lines read data in
          end
        end
        T_CONN: begin
          if (release_i) begin
            bsy_q <= 1'b0; io_q <= 1'b0; ph_q <= 3'h0; st_q <= T_IDLE;
          end else if (xfer_i && !ack_s && !sel_s) begin
            if (ph_q != phase_i) begin
              ph_q <= phase_i; io_q <= phase_i[0]; cnt_q <= 32'h0;
            end else cnt_q <= 32'(`SCSEL_SETTLE_CYC);
            db_q <= wdata_i; dboe_n_q <= ~phase_i[0];
            st_q <= T_XFER;
          end
        end
        T_XFER: begin
          // phase lines settle before req, held until ack drops
          if (cnt_q < 32'(`SCSEL_SETTLE_CYC)) cnt_q <= cnt_q + 32'h1;
          else if (!req_q && !ack_s) req_q <= 1'b1;
          else if (req_q && ack_s) begin
            req_q <= 1'b0; rdata_o <= db_s[7:0];
            done_o <= 1'b1; dboe_n_q <= 1'b1; st_q <= T_CONN;
          end
        end
        default: st_q <= T_IDLE;
      endcase
    end
  end

  // bus drive, phase lines and req owned only here
  assign bus.tgt_bsy_o   = bsy_q;
  assign bus.tgt_sel_o   = sel_q;
  assign bus.tgt_io_o    = io_q;
  assign bus.tgt_cd_o    = ph_q[1];
  assign bus.tgt_msg_o   = ph_q[2];
  assign bus.tgt_req_o   = req_q;
  assign bus.tgt_rst_o   = rst_q;
  assign bus.tgt_db_o    = {~^db_q, db_q};
  assign bus.tgt_db_oe_n = dboe_n_q;
  assign connected_o = (st_q == T_CONN) | (st_q == T_XFER);
  assign busy_o      = (st_q == T_XFER);
endmodule

// ### rtl/scsel_initiator.sv
`timescale 1ns/100ps
`include "scsel_params.svh"
module scsel_initiator
  import scsel_pkg::*;
#(
  parameter int TIMEOUT_CYC = `SCSEL_TIMEOUT_CYC,
  parameter int ABORT_CYC   = `SCSEL_ABORT_CYC
) (
  input  wire logic            mclk_i,      // system clock
  input  wire logic            reset_i,     // sync reset, high
  input  wire logic [7:0]      own_id_i,    // own id bit
  input  wire logic            select_i,    // pulse: start selection (bus already won)
  input  wire logic [7:0]      tgt_id_i,    // target id bit
  input  wire logic            use_rst_i,   // timeout asserts rst
  input  wire logic            atn_req_i,   // level: request message out
  input  wire logic [7:0]      wdata_i,     // byte for out phases
  output logic                 connected_o, // connection held
  output logic [7:0]           peer_id_o,   // other party id
  output scsel_phase_type      phase_o,     // phase of last byte
  output logic                 done_o,      // byte moved pulse
  output logic [7:0]           rdata_o,     // received byte
  output logic                 timeout_o,   // selection timed out pulse
  scsel_bus_if.ini             bus          // scsi bus
);
  typedef enum logic [6:0] {
    I_IDLE = 7'h01, I_DSK = 7'h02, I_WAIT = 7'h04, I_ABT = 7'h08, I_SELREL = 7'h10,
    I_RESEL = 7'h20, I_CONN = 7'h40
  } scsel_istate_type;

  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) n = n + {3'h0, v[i]};
    return n;
  endfunction

  logic [15:0] s1_q, s2_q, s3_q, in_q;
  logic [15:0] raw;
  assign raw = {bus.rst, bus.req, bus.msg, bus.cd, bus.io, bus.sel, bus.bsy, bus.db};
  always_ff @(posedge mclk_i) begin
    s1_q <= raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    for (int i = 0; i < 16; i++) if (s2_q[i] == s3_q[i]) in_q[i] <= s3_q[i];
  end
  logic [8:0] db_s;
  logic bsy_s, sel_s, io_s, req_s, resel_cond;
  assign db_s  = in_q[8:0];
  assign bsy_s = in_q[9];
  assign sel_s = in_q[10];
  assign io_s  = in_q[11];
  assign req_s = in_q[14];
  // reselection seen, screened for parity and exactly two ids
  assign resel_cond = sel_s & io_s & |(db_s[7:0] & own_id_i) & ~bsy_s & (^db_s) & (ones(db_s[7:0]) == 4'h2);

  scsel_istate_type st_q;
  logic [31:0] cnt_q;
  logic [7:0]  db_q;
  logic bsy_q, sel_q, atn_q, rst_q, ack_q, dboe_n_q;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= I_IDLE; cnt_q <= 32'h0; db_q <= 8'h00; bsy_q <= 1'b0; sel_q <= 1'b0; atn_q <= 1'b0;
      rst_q <= 1'b0; ack_q <= 1'b0; dboe_n_q <= 1'b1; peer_id_o <= 8'h00; phase_o <= PH_DATA_OUT;
      done_o <= 1'b0; rdata_o <= 8'h00; timeout_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      timeout_o <= 1'b0;
      case (st_q)
        I_IDLE: begin
          if (select_i) begin
            bsy_q <= 1'b1; sel_q <= 1'b1; atn_q <= 1'b1;
            db_q <= own_id_i | tgt_id_i; dboe_n_q <= 1'b0; cnt_q <= 32'h0; st_q <= I_DSK;
          end else if (resel_cond) begin
            cnt_q <= cnt_q + 32'h1;
            if (cnt_q + 32'h1 >= 32'(`SCSEL_SETTLE_CYC)) begin
              bsy_q <= 1'b1; peer_id_o <= db_s[7:0] & ~own_id_i; st_q <= I_RESEL;
            end
          end else cnt_q <= 32'h0;
        end
        I_DSK: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q + 32'h1 >= 32'(`SCSEL_DESKEW2_CYC)) begin
            bsy_q <= 1'b0; cnt_q <= 32'h0; st_q <= I_WAIT;
          end
        end
        I_WAIT: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q >= 32'(`SCSEL_SETTLE_CYC) && bsy_s) begin
            cnt_q <= 32'h0; st_q <= I_SELREL;
          end else if (cnt_q >= 32'(TIMEOUT_CYC)) begin
            cnt_q <= 32'h0;
            if (use_rst_i) rst_q <= 1'b1;
            else dboe_n_q <= 1'b1;
            st_q <= I_ABT;
          end
        end
        I_ABT: begin
          cnt_q <= cnt_q + 32'h1;
          if (bsy_s && !rst_q) begin
            cnt_q <= 32'h0; st_q <= I_SELREL;
          end else if (cnt_q >= 32'(ABORT_CYC + `SCSEL_DESKEW2_CYC)) begin
            sel_q <= 1'b0; atn_q <= 1'b0; rst_q <= 1'b0; dboe_n_q <= 1'b1;
            timeout_o <= 1'b1; st_q <= I_IDLE;
          end
        end
        I_SELREL: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q + 32'h1 >= 32'(`SCSEL_DESKEW2_CYC)) begin
            sel_q <= 1'b0; dboe_n_q <= 1'b1; peer_id_o <= tgt_id_i; st_q <= I_CONN;
          end
        end
        I_RESEL: if (!sel_s) begin
          bsy_q <= 1'b0; st_q <= I_CONN;
        end
        I_CONN: begin
          atn_q <= atn_req_i;
          if (!bsy_s && !sel_s) begin
            // bus free: let go of every line, attention too
            atn_q <= 1'b0; ack_q <= 1'b0; dboe_n_q <= 1'b1; st_q <= I_IDLE;
          end else if (req_s && !ack_q) begin
            // phase taken as valid only on req
            phase_o <= scsel_phase_type'(in_q[13:11]);
            if (!io_s) begin
              db_q <= wdata_i; dboe_n_q <= 1'b0;
            end else rdata_o <= db_s[7:0];
            ack_q <= 1'b1; done_o <= 1'b1;
          end else if (!req_s && ack_q) begin
            ack_q <= 1'b0; dboe_n_q <= 1'b1;
          end
        end
        default: st_q <= I_IDLE;
      endcase
    end
  end

  assign bus.ini_bsy_o   = bsy_q;
  assign bus.ini_sel_o   = sel_q;
  assign bus.ini_atn_o   = atn_q;
  assign bus.ini_ack_o   = ack_q;
  assign bus.ini_rst_o   = rst_q;
  assign bus.ini_db_o    = {~^db_q, db_q};
  assign bus.ini_db_oe_n = dboe_n_q;
  assign connected_o = (st_q == I_CONN);
endmodule

// ### tb/scsel_assertions.sv
`timescale 1ns/100ps
// watches the shared bus between the two ends
module scsel_assertions #(
  parameter logic [7:0] TGT_ID    = 8'h01,
  parameter int         ABORT_CYC = 50
) (
  input wire logic       mclk_i,    // clock
  input wire logic       reset_i,   // sync reset
  input wire logic       tgt_bsy_o, // target busy drive
  input wire logic       ini_bsy_o, // initiator busy drive
  input wire logic       tgt_sel_o, // target select drive
  input wire logic       ini_sel_o, // initiator select drive
  input wire logic       bsy,       // busy line
  input wire logic       sel,       // select line
  input wire logic       io,        // direction line
  input wire logic       cd,        // control or data line
  input wire logic       msg,       // message line
  input wire logic       req,       // request line
  input wire logic       ack,       // acknowledge line
  input wire logic       atn,       // attention line
  input wire logic [8:0] db         // data and parity
);
  logic       sel_ok;
  logic [7:0] stab_q;
  logic [7:0] ph_q;
  logic [2:0] ph_prev_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // a clean selection of the watched target stands on the wire
  assign sel_ok = sel && !bsy && !io && |(db[7:0] & TGT_ID) && ($countones(db[7:0]) == 2) && ^db;
  // cycles the selection has stood unanswered
  always_ff @(posedge mclk_i) begin
    if (reset_i || !sel_ok) begin
      stab_q <= 8'h00;
    end else if (stab_q != 8'hFF) begin
      stab_q <= stab_q + 8'h01;
    end
  end
  // cycles the phase lines have stood unchanged
  always_ff @(posedge mclk_i) begin
    ph_prev_q <= {msg, cd, io};
    if (reset_i || ph_prev_q != {msg, cd, io}) begin
      ph_q <= 8'h00;
    end else if (ph_q != 8'hFF) begin
      ph_q <= ph_q + 8'h01;
    end
  end
  sequence s_sel_setup;
    ini_sel_o && atn && !io && ($countones(db[7:0]) == 2);
  endsequence
  sequence s_bsy_hold;
    ini_bsy_o [*4] ##[1:8] !ini_bsy_o;
  endsequence
  property p_sel_setup;
    $rose(ini_sel_o) |-> ##[0:1] s_sel_setup;
  endproperty
  a_sel_setup: assert property (p_sel_setup) else $error("selection set up wrongly");
  property p_sel_bsy_drop;
    $rose(ini_sel_o) |-> s_bsy_hold;
  endproperty
  a_sel_bsy_drop: assert property (p_sel_bsy_drop) else $error("busy dropped at wrong time");
  property p_tgt_settled;
    $rose(tgt_bsy_o) && $past(sel) && !tgt_sel_o |-> stab_q >= 8'd20;
  endproperty
  a_tgt_settled: assert property (p_tgt_settled) else $error("target answered unsettled");
  property p_tgt_bound;
    stab_q < 8'(ABORT_CYC + 30);
  endproperty
  a_tgt_bound: assert property (p_tgt_bound) else $error("target answer too late");
  property p_sel_release;
    $fell(ini_sel_o) && bsy |-> $past(bsy, 5);
  endproperty
  a_sel_release: assert property (p_sel_release) else $error("select released too early");
  property p_req_after_sel;
    $rose(req) |-> !sel && !$past(sel, 2);
  endproperty
  a_req_after_sel: assert property (p_req_after_sel) else $error("request while selecting");
  property p_xfer_bus;
    (req || ack) |-> bsy && !sel;
  endproperty
  a_xfer_bus: assert property (p_xfer_bus) else $error("busy or select wrong in transfer");
  property p_phase_env;
    (req || ack) |-> $stable({msg, cd, io}) && (!$rose(req) || ph_q >= 8'd19);
  endproperty
  a_phase_env: assert property (p_phase_env) else $error("phase lines not enveloping");
  property p_phase_code;
    req |-> !({msg, cd, io} inside {3'h4, 3'h5});
  endproperty
  a_phase_code: assert property (p_phase_code) else $error("reserved phase code");
  property p_resel_hand;
    $fell(tgt_sel_o) && bsy |-> (tgt_bsy_o && $past(tgt_bsy_o, 5)) ##0 (tgt_bsy_o throughout ##[1:12] !ini_bsy_o);
  endproperty
  a_resel_hand: assert property (p_resel_hand) else $error("reselection handover wrong");
  property p_abort_release;
    $fell(ini_sel_o) && !bsy |-> !atn;
  endproperty
  a_abort_release: assert property (p_abort_release) else $error("attention kept after abort");
endmodule

// ### tb/scsi_selection_phase_control_bench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (b)); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && !(c); k++) begin @(posedge mclk_i); #2; end end
module scsi_selection_phase_control_bench
  import scsel_pkg::*;
;
  logic            mclk_i = 0;
  logic            reset_i = 1;
  logic            resel, xfer, rel, sel_go, atn_rq, t_rst, i_rst, t_con, i_con, t_done, t_to, i_to;
  logic [7:0]      t_wd, i_wd, ini_id, tgt_id, t_pid, i_pid, t_rd, i_rd;
  logic            t_busy, i_done, t2_con, t2_busy, t2_done, t2_to;
  logic [7:0]      t2_pid, t2_rd;
  int              i_cnt = 0;
  logic [7:0]      t_own = 8'h01;
  logic [7:0]      i_own = 8'h80;
  logic [8:0]      v2[3] = '{9'h081, 9'h083, 9'h181};
  scsel_phase_type ph, i_ph;
  scsel_phase_type tab[6] = '{PH_DATA_OUT, PH_DATA_IN, PH_COMMAND, PH_STATUS, PH_MSG_OUT, PH_MSG_IN};
  int              fail_count = 0;
  int              n_checks = 0;
  int              exp_q[$];
  scsel_bus_if bus ();
  scsel_bus_if bus2 ();
  scsel_target #(.TIMEOUT_CYC(200), .ABORT_CYC(50)) i_scsel_target (.mclk_i(mclk_i), .reset_i(reset_i),
    .own_id_i(t_own), .resel_i(resel), .ini_id_i(ini_id), .use_rst_i(t_rst), .xfer_i(xfer), .phase_i(ph),
    .wdata_i(t_wd), .release_i(rel), .connected_o(t_con), .peer_id_o(t_pid), .busy_o(t_busy), .done_o(t_done),
    .rdata_o(t_rd), .timeout_o(t_to), .bus(bus));
  scsel_target #(.TIMEOUT_CYC(200), .ABORT_CYC(50)) i_scsel_target_2 (.mclk_i(mclk_i), .reset_i(reset_i),
    .own_id_i(t_own), .resel_i(1'b0), .ini_id_i(ini_id), .use_rst_i(t_rst), .xfer_i(1'b0), .phase_i(ph),
    .wdata_i(t_wd), .release_i(1'b0), .connected_o(t2_con), .peer_id_o(t2_pid), .busy_o(t2_busy),
    .done_o(t2_done), .rdata_o(t2_rd), .timeout_o(t2_to), .bus(bus2));
  scsel_initiator #(.TIMEOUT_CYC(200), .ABORT_CYC(50)) i_scsel_initiator (.mclk_i(mclk_i), .reset_i(reset_i),
    .own_id_i(i_own), .select_i(sel_go), .tgt_id_i(tgt_id), .use_rst_i(i_rst), .atn_req_i(atn_rq),
    .wdata_i(i_wd), .connected_o(i_con), .peer_id_o(i_pid), .phase_o(i_ph), .done_o(i_done), .rdata_o(i_rd),
    .timeout_o(i_to), .bus(bus));
  scsel_assertions #(.TGT_ID(8'h01), .ABORT_CYC(50)) i_scsel_assertions (.mclk_i(mclk_i), .reset_i(reset_i),
    .tgt_bsy_o(bus.tgt_bsy_o), .ini_bsy_o(bus.ini_bsy_o), .tgt_sel_o(bus.tgt_sel_o), .ini_sel_o(bus.ini_sel_o),
    .bsy(bus.bsy), .sel(bus.sel), .io(bus.io), .cd(bus.cd), .msg(bus.msg), .req(bus.req), .ack(bus.ack),
    .atn(bus.atn), .db(bus.db));
  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;
  // count initiator byte pulses
  always @(posedge mclk_i) if (i_done === 1'b1) i_cnt++;
  task tick(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task do_reset();
    reset_i = 1;
    tick(10);
    reset_i = 0;
    tick(1);
  endtask
  // one byte in the given phase, checked against the model queue
  task move(input scsel_phase_type p);
    logic [7:0] e;
    int         c0;
    t_wd = 8'($urandom);
    i_wd = 8'($urandom);
    ph = p;
    exp_q.push_back(p[0] ? t_wd : i_wd);
    c0 = i_cnt;
    xfer = 1;
    tick(1);
    xfer = 0;
    `CHK(t_busy, 1'b1)
    `WAITC(t_done, 100)
    e = 8'(exp_q.pop_front());
    `CHK({t_done, t_busy}, 2'b10)
    `CHK(i_cnt - c0, 1)
    `CHK({i_ph, (p[0] ? i_rd : t_rd)}, {p, e})
    `WAITC(!bus.ack && !bus.req, 50)
    tick(6);
  endtask
  // connection attempt towards an absent party, with or without bus reset
  task lost(input bit tg, input bit r);
    logic seen;
    seen = 0;
    t_rst = r;
    i_rst = r;
    if (tg) resel = 1; else sel_go = 1;
    tick(1);
    resel = 0;
    sel_go = 0;
    for (int k = 0; k < 400 && !(tg ? t_to : i_to); k++) begin
      @(posedge mclk_i);
      #2;
      seen |= bus.rst;
    end
    `CHK({(tg ? t_to : i_to), seen}, {1'b1, r})
    `WAITC(!bus.sel && !bus.rst && !bus.atn && !bus.io, 200)
    `CHK({bus.sel, bus.atn, bus.io, bus.db}, 12'h000)
    do_reset();
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(20 * 20000);
    fail_count++;
    complete_run();
  end
  initial begin
    {resel, xfer, rel, sel_go, atn_rq, t_rst, i_rst} = '0;
    {t_wd, i_wd, ini_id, tgt_id} = {16'h0000, 16'h8001};
    ph = PH_DATA_OUT;
    {bus2.ini_bsy_o, bus2.ini_sel_o, bus2.ini_atn_o, bus2.ini_ack_o, bus2.ini_rst_o} = '0;
    bus2.ini_db_o = '0;
    bus2.ini_db_oe_n = 1;
    void'($urandom(68));
    do_reset();
    // selection with attention, then every phase code twice
    atn_rq = 1;
    sel_go = 1;
    tick(1);
    sel_go = 0;
    `WAITC(t_con && i_con && !bus.sel, 200)
    `CHK({t_con, i_con, t_pid, i_pid}, {2'b11, 16'h8001})
    atn_rq = 0;
    tick(6);
    foreach (tab[i]) repeat (2) move(tab[i]);
    rel = 1;
    tick(1);
    rel = 0;
    `WAITC(!t_con && !i_con, 100)
    `CHK({t_con, i_con, bus.bsy, bus.io, bus.cd, bus.msg}, 6'h00)
    $display("selection and transfer test done");
    // reselection, one byte, then leave
    tick(30);
    resel = 1;
    tick(1);
    resel = 0;
    `WAITC(t_con && i_con && !bus.sel, 200)
    `CHK({t_pid, i_pid, bus.io}, {16'h8001, 1'b1})
    `WAITC(!bus.ini_bsy_o, 20)
    `CHK({bus.tgt_bsy_o, bus.ini_bsy_o}, 2'b10)
    tick(6);
    move(PH_MSG_IN);
    atn_rq = 1;
    rel = 1;
    tick(1);
    rel = 0;
    `WAITC(!t_con && !i_con, 100)
    `CHK({bus.atn, bus.ack, bus.bsy}, 3'h0)
    $display("reselection test done");
    // time-outs on both sides, abort and bus reset
    {atn_rq, tgt_id, ini_id} = {1'b1, 16'h0240};
    for (int r = 0; r < 2; r++) begin
      lost(1'b0, r[0]);
      lost(1'b1, r[0]);
    end
    $display("time-out test done");
    // second bus: bad parity, three ids, then a clean selection
    for (int i = 0; i < 3; i++) begin
      bus2.ini_db_o = v2[i];
      bus2.ini_db_oe_n = 0;
      {bus2.ini_bsy_o, bus2.ini_sel_o, bus2.ini_atn_o} = 3'h7;
      tick(5);
      bus2.ini_bsy_o = 0;
      tick(80);
      `CHK(bus2.tgt_bsy_o, (i == 2))
      {bus2.ini_sel_o, bus2.ini_atn_o, bus2.ini_db_oe_n} = 3'h1;
      tick(30);
      `CHK({t2_con, t2_pid, t2_busy, t2_done, t2_to, t2_rd}, {(i == 2), ((i == 2) ? 8'h80 : 8'h00), 11'h000})
    end
    $display("faulty selection test done");
    complete_run();
  end
endmodule
